/* File: design/reset_wake_pkg.sv */
// constants for the reset and wake-up register initialisation block
// Notes on behaviour
// - three event classes, each with own initial values
// - interrupt wake with enable set pushes PC
// - interrupt wake with enable loads priority vector
// - every wake-up sets a recorded source flag
// - port bits 6,7 live only when oscillator frees
// - unimplemented bit positions always read zero
package reset_wake_pkg;
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam logic [PC_W-1:0] RESET_VECTOR = 21'h000000;
  localparam logic [PC_W-1:0] HIGH_VECTOR = 21'h000008;
  localparam logic [PC_W-1:0] LOW_VECTOR = 21'h000018;
  localparam logic [SP_W-1:0] SP_RESET = 5'h00;
  localparam logic [SP_W-1:0] SP_LAST = 5'h1f;
  localparam logic [7:0] PORT_LOW_MASK = 8'h3f;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [2:0] FLAG_RESET = 3'h0;
  localparam int FLAG_WDT = 0;
  localparam int FLAG_HIGH = 1;
  localparam int FLAG_LOW = 2;
  typedef enum logic [1:0] {
    EV_NONE, EV_COLD, EV_WARM, EV_WAKE
  } event_class_t;
endpackage : reset_wake_pkg

/* File: design/reset_wake_register_init.sv */
// applies initial register state for each reset or wake-up event
`timescale 1ns/1ps
`default_nettype none
module reset_wake_register_init
  import reset_wake_pkg::*;
(
  input wire logic clk_sys, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic power_on_event, // power-on or brown-out pulse
  input wire logic external_reset_pin_event, // pin reset pulse
  input wire logic watchdog_timer_reset, // watchdog reset pulse
  input wire logic reset_instr_event, // reset instruction pulse
  input wire logic stack_reset_event, // stack fault reset pulse
  input wire logic config_mismatch_event, // mismatch reset pulse
  input wire logic watchdog_timer_wake, // watchdog wake from sleep
  input wire logic irq_wake_high, // high-priority source wake
  input wire logic irq_wake_low, // low-priority source wake
  input wire logic high_global_irq_enable, // high global enable
  input wire logic low_global_irq_enable, // low global enable
  input wire logic osc_frees_upper, // oscillator frees port bits 6,7
  input wire logic [PC_W-1:0] pc_in, // current program counter
  input wire logic [SP_W-1:0] sp_in, // current stack pointer
  input wire logic latch_we, // core write to port latch
  input wire logic [7:0] latch_wdata, // latch write data
  input wire logic dir_we, // core write to port direction
  input wire logic [7:0] dir_wdata, // direction write data
  input wire logic [7:0] pin_level, // sampled port pin levels
  input wire logic flag_clear, // clears the wake source flags
  output logic pc_load, // pulse: load pc_out into PC
  output logic [PC_W-1:0] pc_out, // value for PC
  output logic stack_we, // pulse: write stack_top at return_stack_pointer
  output logic [7:0] stack_top_upper, // pushed PC upper byte
  output logic [7:0] stack_top_high, // pushed PC high byte
  output logic [7:0] stack_top_low, // pushed PC low byte
  output logic [SP_W-1:0] return_stack_pointer, // stack pointer value
  output logic sp_load, // pulse: load return_stack_pointer
  output logic [2:0] irq_flag_regs, // wake source flags
  output logic [7:0] first_port_pins, // port pin read value
  output logic [7:0] first_port_latch, // port latch read value
  output logic [7:0] first_port_direction, // port direction value
  output event_class_t last_event // class of most recent event
);
  event_class_t ev;
  event_class_t next_last_event;
  logic cold;
  logic warm;
  logic wake;
  logic irq_wake;
  logic any_enable;
  logic reset_class;
  logic vec_wake;
  wire [7:0] mask;
  logic next_pc_load;
  logic [PC_W-1:0] next_pc_out;
  logic next_stack_we;
  logic next_sp_load;
  logic [SP_W-1:0] next_sp;
  logic [SP_W-1:0] sp_pushed;
  logic [23:0] pushed_word;
  logic [7:0] next_tos_upper;
  logic [7:0] next_tos_high;
  logic [7:0] next_tos_low;
  logic [2:0] next_flags;
  logic [7:0] next_latch;
  logic [7:0] next_dir;
  logic [7:0] next_pins;

  assign cold = power_on_event;
  assign warm = external_reset_pin_event | watchdog_timer_reset |
                reset_instr_event | stack_reset_event |
                config_mismatch_event;
  assign irq_wake = irq_wake_high | irq_wake_low;
  assign wake = watchdog_timer_wake | irq_wake;
  // cold outranks warm outranks wake when several arrive together
  assign ev = cold ? EV_COLD : warm ? EV_WARM : wake ? EV_WAKE : EV_NONE;
  assign reset_class = (ev == EV_COLD) || (ev == EV_WARM);
  assign any_enable = high_global_irq_enable | low_global_irq_enable;
  // with both enables clear a wake only records its source
  assign vec_wake = (ev == EV_WAKE) && irq_wake && any_enable;

  // bits 6 and 7 live only when the oscillator frees their pins
  for (genvar b = 0; b < 8; b++) begin : g_mask_bit
    assign mask[b] = PORT_LOW_MASK[b] | osc_frees_upper;
  end

  // class of the most recent event, held until the next one
  always_comb begin
    next_last_event = last_event;
    if (ev != EV_NONE) begin
      next_last_event = ev;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_event <= EV_NONE;
    end else begin
      last_event <= next_last_event;
    end
  end

  always_comb begin
    next_pc_load = 1'b0;
    next_pc_out = pc_out;
    if (reset_class) begin
      next_pc_load = 1'b1;
      next_pc_out = RESET_VECTOR;
    end else if (vec_wake) begin
      next_pc_load = 1'b1;
      // a high source wins the vector when both wake together
      next_pc_out = irq_wake_high ? HIGH_VECTOR : LOW_VECTOR;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc_load <= 1'b0;
      pc_out <= RESET_VECTOR;
    end else begin
      pc_load <= next_pc_load;
      pc_out <= next_pc_out;
    end
  end

  // saturate at the last entry; overflow status belongs to the stack
  assign sp_pushed = (sp_in == SP_LAST) ? SP_LAST : sp_in + 5'h01;
  // pc is narrower than three stack bytes; spare upper bits stay zero
  assign pushed_word = {3'h0, pc_in};

  always_comb begin
    next_stack_we = 1'b0;
    next_sp_load = 1'b0;
    next_sp = return_stack_pointer;
    next_tos_upper = stack_top_upper;
    next_tos_high = stack_top_high;
    next_tos_low = stack_top_low;
    if (reset_class) begin
      next_sp_load = 1'b1;
      next_sp = SP_RESET;
    end else if (vec_wake) begin
      next_stack_we = 1'b1;
      next_sp_load = 1'b1;
      next_sp = sp_pushed;
      next_tos_upper = pushed_word[23:16];
      next_tos_high = pushed_word[15:8];
      next_tos_low = pushed_word[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stack_we <= 1'b0;
      sp_load <= 1'b0;
      return_stack_pointer <= SP_RESET;
      stack_top_upper <= 8'h00;
      stack_top_high <= 8'h00;
      stack_top_low <= 8'h00;
    end else begin
      stack_we <= next_stack_we;
      sp_load <= next_sp_load;
      return_stack_pointer <= next_sp;
      stack_top_upper <= next_tos_upper;
      stack_top_high <= next_tos_high;
      stack_top_low <= next_tos_low;
    end
  end

  always_comb begin
    next_flags = irq_flag_regs;
    if (flag_clear) begin
      next_flags = FLAG_RESET;
    end
    // a source arriving with the clear still sets its bit
    if (reset_class) begin
      next_flags = FLAG_RESET;
    end else if (ev == EV_WAKE) begin
      if (watchdog_timer_wake) begin
        next_flags[FLAG_WDT] = 1'b1;
      end
      if (irq_wake_high) begin
        next_flags[FLAG_HIGH] = 1'b1;
      end
      if (irq_wake_low) begin
        next_flags[FLAG_LOW] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_regs <= FLAG_RESET;
    end else begin
      irq_flag_regs <= next_flags;
    end
  end

  // ports hold across sleep; only core writes change them then
  always_comb begin
    next_latch = first_port_latch;
    next_dir = first_port_direction;
    if (latch_we) begin
      next_latch = latch_wdata;
    end
    if (dir_we) begin
      next_dir = dir_wdata;
    end
    case (ev)
      EV_COLD: begin
        next_latch = PORT_RESET;
        next_dir = DIR_RESET;
      end
      EV_WARM: begin
        // the latch survives a warm reset, the direction does not
        next_dir = DIR_RESET;
      end
      default: begin
      end
    endcase
    next_latch = next_latch & mask;
    next_dir = next_dir & mask;
    next_pins = pin_level & mask;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      first_port_latch <= PORT_RESET;
      // reset value comes up without the upper pins
      first_port_direction <= DIR_RESET & PORT_LOW_MASK;
      first_port_pins <= PORT_RESET;
    end else begin
      first_port_latch <= next_latch;
      first_port_direction <= next_dir;
      first_port_pins <= next_pins;
    end
  end
endmodule : reset_wake_register_init
`default_nettype wire

/* File: tb/reset_wake_sva.sv */
// assertion checker for the reset and wake-up block
`timescale 1ns/1ps
`default_nettype none
module reset_wake_sva
  import reset_wake_pkg::*;
(
  input wire logic clk_sys, rst_n, power_on_event, external_reset_pin_event,
  input wire logic watchdog_timer_reset, reset_instr_event, stack_reset_event,
  input wire logic config_mismatch_event, watchdog_timer_wake, irq_wake_high,
  input wire logic irq_wake_low, high_global_irq_enable, low_global_irq_enable,
  input wire logic osc_frees_upper, pc_load, stack_we, sp_load, flag_clear,
  input wire logic [PC_W-1:0] pc_in, pc_out,
  input wire logic [SP_W-1:0] sp_in, return_stack_pointer,
  input wire logic [7:0] stack_top_upper, stack_top_high, stack_top_low,
  input wire logic [7:0] first_port_latch, first_port_direction,
  input wire logic [7:0] first_port_pins,
  input wire logic [2:0] irq_flag_regs,
  input wire event_class_t last_event
);
  wire warm = external_reset_pin_event | watchdog_timer_reset |
    reset_instr_event | stack_reset_event | config_mismatch_event;
  wire quiet = !power_on_event && !warm;
  wire ge = high_global_irq_enable | low_global_irq_enable;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence hi_wake; quiet && irq_wake_high && ge; endsequence
  sequence dog_wake;
    quiet && watchdog_timer_wake && !irq_wake_high && !irq_wake_low;
  endsequence
  sequence lo_wake;
    quiet && irq_wake_low && !irq_wake_high && ge;
  endsequence
  sequence any_vec;
    quiet && (irq_wake_high || irq_wake_low) && ge && sp_in != SP_LAST;
  endsequence
  sequence dog_clear; dog_wake ##0 flag_clear; endsequence
  cold_init_a: assert property (power_on_event |=>
    last_event == EV_COLD && pc_out == RESET_VECTOR) else $error("cold");
  warm_init_a: assert property (warm && !power_on_event |=>
    last_event == EV_WARM && pc_out == RESET_VECTOR) else $error("warm");
  pc_push_a: assert property (hi_wake |=> stack_we &&
    {stack_top_upper, stack_top_high, stack_top_low} == {3'h0, $past(pc_in)})
    else $error("push");
  hi_vector_a: assert property (hi_wake |=>
    pc_load && pc_out == HIGH_VECTOR) else $error("high vector");
  dog_flag_a: assert property (dog_wake |=>
    irq_flag_regs[FLAG_WDT]) else $error("wake flag");
  upper_off_a: assert property ((!osc_frees_upper)[*2] |->
    first_port_latch[7:6] == 2'h0 && first_port_direction[7:6] == 2'h0)
    else $error("upper bits");
  unused_zero_a: assert property (stack_top_upper[7:5] == 3'h0)
    else $error("unused bits");
  dog_keep_a: assert property (dog_wake |=> !pc_load && !stack_we)
    else $error("wake keep");
  lo_vector_a: assert property (lo_wake |=>
    pc_load && pc_out == LOW_VECTOR) else $error("low vector");
  sp_push_a: assert property (any_vec |=> sp_load &&
    return_stack_pointer == $past(sp_in) + 5'h01) else $error("sp push");
  set_wins_a: assert property (dog_clear |=>
    irq_flag_regs == (3'h1 << FLAG_WDT)) else $error("set wins");
  pins_zero_a: assert property (!osc_frees_upper |=>
    first_port_pins[7:6] == 2'h0) else $error("pins upper");
endmodule : reset_wake_sva
`default_nettype wire

/* File: tb/reset_wake_register_init_bench.sv */
// self-checking bench for the reset and wake-up block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module reset_wake_register_init_bench;
  import reset_wake_pkg::*;
  logic clk_sys = 0, rst_n = 0, por = 0, dog = 0, hw = 0, lw = 0, he = 0;
  logic le = 0, osc = 1, lwe = 0, pcl, swe;
  logic dwe = 0, fclr = 0, spl;
  logic [7:0] dwd = 0, pin = 0, pins;
  logic [4:0] warm = 0;
  logic [7:0] lwd = 0, tu, th, tl, lat, dir;
  logic [PC_W-1:0] pco;
  logic [SP_W-1:0] rsp;
  logic [2:0] flg;
  event_class_t ev;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  reset_wake_register_init dut (.clk_sys, .rst_n, .power_on_event(por),
    .external_reset_pin_event(warm[0]), .watchdog_timer_reset(warm[1]),
    .reset_instr_event(warm[2]), .stack_reset_event(warm[3]),
    .config_mismatch_event(warm[4]), .watchdog_timer_wake(dog),
    .irq_wake_high(hw), .irq_wake_low(lw), .high_global_irq_enable(he),
    .low_global_irq_enable(le), .osc_frees_upper(osc), .pc_in(21'h1abcd6),
    .sp_in(5'h03), .latch_we(lwe), .latch_wdata(lwd), .dir_we(dwe),
    .dir_wdata(dwd), .pin_level(pin), .flag_clear(fclr), .pc_load(pcl),
    .pc_out(pco), .stack_we(swe), .stack_top_upper(tu), .stack_top_high(th),
    .stack_top_low(tl), .return_stack_pointer(rsp), .sp_load(spl),
    .irq_flag_regs(flg), .first_port_pins(pins), .first_port_latch(lat),
    .first_port_direction(dir), .last_event(ev));
  initial forever #4 clk_sys = ~clk_sys;
  task automatic tick; @(posedge clk_sys); endtask : tick
  task automatic wr(input logic [7:0] d);
    tick; lwe <= 1; lwd <= d;
    tick; lwe <= 0;
  endtask : wr
  task automatic t_cold;
    wr(8'ha5); por <= 1;
    tick; por <= 0; #1;
    `CHK("lat", 8'h00, lat)
    `CHK("dir", DIR_RESET, dir)
    `CHK("ev", EV_COLD, ev)
    `CHK("sp", SP_RESET, rsp)
    `CHK("pcl", 1'b1, pcl)
  endtask : t_cold
  task automatic t_port;
    tick; dwe <= 1; dwd <= 8'hc3; pin <= 8'hff;
    tick; dwe <= 0;
    tick; #1;
    `CHK("dir", 8'hc3, dir)
    `CHK("pins", 8'hff, pins)
  endtask : t_port
  task automatic t_warm;
    wr(8'h5a);
    for (int i = 0; i < 5; i++) begin
      tick; warm <= 5'h01 << i;
      tick; warm <= 0; #1;
      `CHK("lat", 8'h5a, lat)
      `CHK("dir", DIR_RESET, dir)
      `CHK("ev", EV_WARM, ev)
    end
  endtask : t_warm
  task automatic t_wake(input logic h, input logic [PC_W-1:0] v);
    tick; he <= h; le <= !h; hw <= h; lw <= !h;
    tick; hw <= 0; lw <= 0; #1;
    `CHK("pc", v, pco)
    `CHK("sp", 5'h04, rsp)
    `CHK("flg", h ? 3'h2 : 3'h6, flg)
    `CHK("lat", 8'h5a, lat)
    `CHK("pcl", 1'b1, pcl)
    `CHK("swe", 1'b1, swe)
    `CHK("tos", {3'h0, 21'h1abcd6}, {tu, th, tl})
    `CHK("ev", EV_WAKE, ev)
  endtask : t_wake
  task automatic t_dog;
    tick; he <= 0; le <= 0; dog <= 1;
    tick; dog <= 0; #1;
    `CHK("push", 1'b0, swe)
    `CHK("flg", 3'h7, flg)
    `CHK("pc", LOW_VECTOR, pco)
    `CHK("pcl", 1'b0, pcl)
  endtask : t_dog
  task automatic t_clear;
    tick; fclr <= 1;
    tick; dog <= 1; #1;
    `CHK("clr", 3'h0, flg)
    tick; dog <= 0; fclr <= 0; #1;
    `CHK("set", 3'h1, flg)
  endtask : t_clear
  task automatic t_rewarm;
    tick; warm <= 5'h08;
    tick; warm <= 0; #1;
    `CHK("pc", RESET_VECTOR, pco)
    `CHK("sp", SP_RESET, rsp)
    `CHK("spl", 1'b1, spl)
    `CHK("flg", FLAG_RESET, flg)
  endtask : t_rewarm
  task automatic t_osc;
    tick; osc <= 0; wr(8'hff); tick; #1;
    `CHK("lat", 8'h3f, lat)
    `CHK("dir", 8'h3f, dir)
    `CHK("pins", 8'h3f, pins)
  endtask : t_osc
  task automatic t_reset;
    tick; rst_n <= 0;
    tick; #1;
    `CHK("rst dir", DIR_RESET & PORT_LOW_MASK, dir)
    `CHK("rst pins", 8'h00, pins)
    `CHK("rst ev", EV_NONE, ev)
    tick; rst_n <= 1;
    tick; #1;
    `CHK("rel pins", 8'h3f, pins)
    `CHK("rel pcl", 1'b0, pcl)
  endtask : t_reset
  task automatic conclude;
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // ceiling well above the few dozen cycles the sequence needs
  always @(posedge clk_sys) if (++cyc > 500) begin
    n_mismatch++;
    conclude;
  end
  initial begin
    repeat (3) tick;
    rst_n <= 1;
    t_cold; t_port; t_warm; t_wake(1, HIGH_VECTOR); t_wake(0, LOW_VECTOR);
    t_dog; t_clear; t_rewarm; t_osc; t_reset; conclude;
  end
endmodule : reset_wake_register_init_bench
bind reset_wake_register_init reset_wake_sva chk (.*);
`default_nettype wire
